// ===== logic/carrier_pkg.sv
package carrier_pkg;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int COUNT_W = 8;                        // Counter and compare width
  localparam logic [7:0] COUNT_CLEAR = 8'h00;        // Counter cleared value
  localparam logic [7:0] COMPARE_RESET = 8'h01;      // Compare reset value
  localparam logic CARRIER_DEFAULT = 1'b0;           // Carrier default level

  // ----------------------------------------------------------------
  // Timing constants
  // ----------------------------------------------------------------
  localparam int SYNC_STAGES = 2;                    // Companion event synchroniser depth
  localparam int TRANSFER_DELAY = 2;                 // Count clocks from event rise to copy
  localparam int HIGH_SETTLE_CLOCKS = 3;             // Count clocks before new high value usable
  localparam logic [1:0] SETTLE_INIT = 2'h0;         // Settle counter start
  localparam logic [1:0] SETTLE_DONE = 2'h3;         // Settle counter saturation value

  // ----------------------------------------------------------------
  // Compare phase, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PHASE_LOW  = 2'b01,                              // Comparing against low width
    PHASE_HIGH = 2'b10                               // Comparing against high width
  } phase_type;

  // ----------------------------------------------------------------
  // Configuration bundle from software
  // ----------------------------------------------------------------
  typedef struct packed {
    logic run_enable;                                // Timer run enable
    logic remote_mode;                               // Remote output mode
    logic [7:0] low_width;                           // Low width compare
    logic [7:0] high_width;                          // High width compare
  } config_type;

endpackage

// ===== logic/carrier_event_sync.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Two-stage synchroniser plus rising-edge detect on the second stage
// ------------------------------------------------------------------
module carrier_event_sync #(
  parameter int STAGES = 2
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic async_in,
  output logic level_out,
  output logic rise_out
);

  logic [STAGES-1:0] sync_q; // Stage 0 feeds only stage 1
  logic last_q; // Previous synchronised level

  // Shift chain; only the last stage is looked at by logic
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sync_q <= '0;
    end else begin
      sync_q <= {sync_q[STAGES-2:0], async_in};
    end
  end

  // Remember last level for edge detect
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      last_q <= 1'b0;
    end else begin
      last_q <= sync_q[STAGES-1];
    end
  end

  assign level_out = sync_q[STAGES-1];
  assign rise_out = sync_q[STAGES-1] & ~last_q;

endmodule

// ===== logic/carrier_generator_timer.sv
`timescale 1ns/1ps
module carrier_generator_timer (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic RUN_ENABLE,
  input wire logic REMOTE_MODE,
  input wire logic [7:0] LOW_WIDTH_COMPARE,
  input wire logic [7:0] HIGH_WIDTH_COMPARE,
  input wire logic HIGH_WIDTH_WRITE,
  input wire logic BUFFER_WRITE,
  input wire logic BUFFER_WRITE_DATA,
  input wire logic COMPANION_MATCH_IRQ,
  output logic CARRIER_OUT_PIN,
  output logic TIMER_MATCH_IRQ,
  output logic SYNCED_COMPANION_EVENT,
  output logic CARRIER_ENABLE_BUFFER,
  output logic CARRIER_ENABLE_ACTIVE,
  output logic [7:0] COUNT_VALUE
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  carrier_pkg::config_type cfg; // Grouped software settings
  carrier_pkg::phase_type phase_q; // Which compare is live
  logic [7:0] count_q; // Timer counter
  logic carrier_q; // Raw carrier clock
  logic gate_q; // Output gate that follows active bit while carrier is low
  logic buffer_q; // Buffered enable
  logic active_q; // Active enable
  logic [7:0] high_live_q; // High compare in use
  logic [7:0] high_pend_q; // Latched new high value
  logic pend_valid_q; // A new high value waits
  logic [1:0] settle_q; // Count clocks since high write
  logic [1:0] xfer_q; // Transfer delay pipe
  logic irq_q; // Registered timer match pulse
  logic sync_level; // Synced companion irq level
  logic sync_rise; // Rising edge of synced event
  logic match; // Counter equals live compare
  logic [7:0] compare_now; // Live compare value

  assign cfg = '{run_enable: RUN_ENABLE, remote_mode: REMOTE_MODE,
                 low_width: LOW_WIDTH_COMPARE, high_width: HIGH_WIDTH_COMPARE};

  // ----------------------------------------------------------------
  // Companion event crossing
  // ----------------------------------------------------------------
  carrier_event_sync #(
    .STAGES(carrier_pkg::SYNC_STAGES)
  ) u_sync (
    .clock(CLOCK),
    .reset(RESET),
    .async_in(COMPANION_MATCH_IRQ),
    .level_out(sync_level),
    .rise_out(sync_rise)
  );

  // ----------------------------------------------------------------
  // Compare selection
  // ----------------------------------------------------------------
  // Low register times the low half, high the high half
  assign compare_now = (phase_q == carrier_pkg::PHASE_LOW) ? cfg.low_width : high_live_q;
  assign match = cfg.run_enable & (count_q == compare_now);

  // Counter: runs while enabled, cleared on any match
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      count_q <= carrier_pkg::COUNT_CLEAR;
    end else if (!cfg.run_enable) begin
      count_q <= carrier_pkg::COUNT_CLEAR;
    end else if (match) begin
      count_q <= carrier_pkg::COUNT_CLEAR;
    end else begin
      count_q <= count_q + 8'h01;
    end
  end

  // Phase: low first after start, toggled by each match
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      phase_q <= carrier_pkg::PHASE_LOW;
    end else if (!cfg.run_enable) begin
      phase_q <= carrier_pkg::PHASE_LOW;
    end else if (match) begin
      unique case (phase_q)
        carrier_pkg::PHASE_LOW: begin
          phase_q <= carrier_pkg::PHASE_HIGH;
        end
        carrier_pkg::PHASE_HIGH: begin
          phase_q <= carrier_pkg::PHASE_LOW;
        end
        default: begin
          phase_q <= carrier_pkg::PHASE_LOW;
        end
      endcase
    end
  end

  // Carrier toggles on every match, so period is N+1 low plus M+1 high
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      carrier_q <= carrier_pkg::CARRIER_DEFAULT;
    end else if (!cfg.run_enable) begin
      carrier_q <= carrier_pkg::CARRIER_DEFAULT;
    end else if (match) begin
      carrier_q <= ~carrier_q;
    end
  end

  // Timer match pulse on each match
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= match;
    end
  end

  // ----------------------------------------------------------------
  // High width compare reload
  // ----------------------------------------------------------------
  // Any write restarts the settle count; three clocks are needed
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      settle_q <= carrier_pkg::SETTLE_INIT;
    end else if (HIGH_WIDTH_WRITE) begin
      settle_q <= carrier_pkg::SETTLE_INIT;
    end else if (settle_q != carrier_pkg::SETTLE_DONE) begin
      settle_q <= settle_q + 2'h1;
    end
  end

  // Latch new value; while stopped it loads directly, which is why a restart needs a write
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      high_pend_q <= carrier_pkg::COMPARE_RESET;
      pend_valid_q <= 1'b0;
      high_live_q <= carrier_pkg::COMPARE_RESET;
    end else if (HIGH_WIDTH_WRITE) begin
      high_pend_q <= cfg.high_width;
      pend_valid_q <= 1'b1;
      if (!cfg.run_enable) begin
        high_live_q <= cfg.high_width;
      end
    end else if (pend_valid_q && match && phase_q == carrier_pkg::PHASE_HIGH
                 && settle_q == carrier_pkg::SETTLE_DONE) begin
      high_live_q <= high_pend_q;
      pend_valid_q <= 1'b0;
    end else if (pend_valid_q && !cfg.run_enable && settle_q == carrier_pkg::SETTLE_DONE) begin
      high_live_q <= high_pend_q;
      pend_valid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Master/slave carrier enable
  // ----------------------------------------------------------------
  // Software writes the buffer only
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      buffer_q <= 1'b0;
    end else if (BUFFER_WRITE) begin
      buffer_q <= BUFFER_WRITE_DATA;
    end
  end

  // Delay pipe: copy lands on second clock after the event rise
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      xfer_q <= 2'b00;
    end else begin
      xfer_q <= {xfer_q[0], sync_rise};
    end
  end

  // Active bit only changes by transfer
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      active_q <= 1'b0;
    end else if (xfer_q[carrier_pkg::TRANSFER_DELAY-2]) begin
      active_q <= buffer_q;
    end
  end

  // Gate opens and closes only while carrier is low or the timer is stopped, keeping whole high pulses
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      gate_q <= 1'b0;
    end else if (!carrier_q || !cfg.run_enable) begin
      gate_q <= active_q;
    end
  end

  // ----------------------------------------------------------------
  // Output pin
  // ----------------------------------------------------------------
  // Remote off: level from active bit; remote on: gated carrier
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      CARRIER_OUT_PIN <= carrier_pkg::CARRIER_DEFAULT;
    end else if (!cfg.remote_mode) begin
      CARRIER_OUT_PIN <= active_q;
    end else begin
      CARRIER_OUT_PIN <= gate_q & carrier_q;
    end
  end

  // Status outputs, all registered
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      TIMER_MATCH_IRQ <= 1'b0;
      SYNCED_COMPANION_EVENT <= 1'b0;
      CARRIER_ENABLE_BUFFER <= 1'b0;
      CARRIER_ENABLE_ACTIVE <= 1'b0;
      COUNT_VALUE <= carrier_pkg::COUNT_CLEAR;
    end else begin
      TIMER_MATCH_IRQ <= irq_q;
      SYNCED_COMPANION_EVENT <= sync_level;
      CARRIER_ENABLE_BUFFER <= buffer_q;
      CARRIER_ENABLE_ACTIVE <= active_q;
      COUNT_VALUE <= count_q;
    end
  end

endmodule

// ===== verif/carrier_generator_timer_assertions.sv
`timescale 1ns/1ps
module carrier_generator_timer_assertions (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic RUN_ENABLE,
  input wire logic REMOTE_MODE,
  input wire logic [7:0] LOW_WIDTH_COMPARE,
  input wire logic [7:0] HIGH_WIDTH_COMPARE,
  input wire logic HIGH_WIDTH_WRITE,
  input wire logic BUFFER_WRITE,
  input wire logic BUFFER_WRITE_DATA,
  input wire logic COMPANION_MATCH_IRQ,
  input wire logic CARRIER_OUT_PIN,
  input wire logic TIMER_MATCH_IRQ,
  input wire logic SYNCED_COMPANION_EVENT,
  input wire logic CARRIER_ENABLE_BUFFER,
  input wire logic CARRIER_ENABLE_ACTIVE,
  input wire logic [7:0] COUNT_VALUE
);
  // ----------------------------------------------------------------
  // One count clock domain, so one default clocking
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);
  a_stop_holds_zero: assert property ((!RUN_ENABLE)[*3] |-> COUNT_VALUE == 8'h00)
    else $error("counter not held at zero while stopped");
  a_count_steps: assert property (RUN_ENABLE && $past(RUN_ENABLE) && $past(RUN_ENABLE, 2)
    && COUNT_VALUE != 8'h00 |-> COUNT_VALUE == $past(COUNT_VALUE) + 8'h01)
    else $error("counter skipped a value");
  a_irq_marks_clear: assert property (RUN_ENABLE[*3] |-> TIMER_MATCH_IRQ ==
    (COUNT_VALUE == 8'h00 && $past(COUNT_VALUE) != 8'h00))
    else $error("match pulse not tied to counter clear");
  a_irq_one_cycle: assert property (TIMER_MATCH_IRQ |=> !TIMER_MATCH_IRQ)
    else $error("match pulse longer than one cycle");
  a_local_follow: assert property (!REMOTE_MODE && $past(!REMOTE_MODE)
    && $stable(CARRIER_ENABLE_ACTIVE) |-> CARRIER_OUT_PIN == CARRIER_ENABLE_ACTIVE)
    else $error("pin does not follow active bit");
  a_gate_closed: assert property ((REMOTE_MODE && !CARRIER_ENABLE_ACTIVE)[*4]
    |-> !$rose(CARRIER_OUT_PIN))
    else $error("pin rose with carrier gated off");
  a_edges_on_match: assert property ((RUN_ENABLE && REMOTE_MODE)[*4] ##0
    $changed(CARRIER_OUT_PIN) |-> TIMER_MATCH_IRQ)
    else $error("pin edge away from a carrier edge");
  a_transfer_source: assert property ($changed(CARRIER_ENABLE_ACTIVE) |->
    CARRIER_ENABLE_ACTIVE == $past(CARRIER_ENABLE_BUFFER) && $past(SYNCED_COMPANION_EVENT)
    && !$past(SYNCED_COMPANION_EVENT, 3))
    else $error("active bit changed without transfer event");
  a_buffer_write: assert property (BUFFER_WRITE ##1 !BUFFER_WRITE |=>
    CARRIER_ENABLE_BUFFER == $past(BUFFER_WRITE_DATA, 2))
    else $error("buffer readback wrong after write");
  c_match: cover property (TIMER_MATCH_IRQ && CARRIER_OUT_PIN);
  c_active_on: cover property ($rose(CARRIER_ENABLE_ACTIVE));
  c_active_off: cover property ($fell(CARRIER_ENABLE_ACTIVE) && REMOTE_MODE);
endmodule
bind carrier_generator_timer carrier_generator_timer_assertions chk_u (.*);

// ===== verif/companion_counter_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Companion counter: match level lasts HOLD companion clocks
// ----------------------------------------------------------------
module companion_counter_model #(
  parameter int PERIOD = 16,
  parameter int HOLD = 6
) (
  input wire logic clock,
  input wire logic run_enable,
  output logic match_irq
);
  int count_q = 0; // Companion count
  // Restart from zero whenever stopped, so each run gives one fresh match
  always @(negedge clock) begin
    if (!run_enable) begin
      count_q <= 0;
    end else begin
      count_q <= (count_q == PERIOD - 1) ? 0 : count_q + 1;
    end
  end
  // Held HOLD count clocks: companion runs on the same clock as the timer
  assign match_irq = run_enable && (count_q >= PERIOD - HOLD);
endmodule

// ===== verif/carrier_generator_timer_tb.sv
`timescale 1ns/1ps
module carrier_generator_timer_tb;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic run = 1'b0;
  logic remote = 1'b0;
  logic [7:0] low_w = 8'h02;
  logic [7:0] high_w = 8'h01;
  logic high_wr = 1'b0;
  logic buf_wr = 1'b0;
  logic buf_data = 1'b0;
  logic comp_run = 1'b0;
  logic comp_irq, pin, irq, sync_ev, en_buf, en_act;
  logic [7:0] count;
  int errors = 0;
  int cmp_count = 0;
  int gap;
  always #20 clock = ~clock;
  carrier_generator_timer dut_u (.CLOCK(clock), .RESET(reset), .RUN_ENABLE(run),
    .REMOTE_MODE(remote), .LOW_WIDTH_COMPARE(low_w), .HIGH_WIDTH_COMPARE(high_w),
    .HIGH_WIDTH_WRITE(high_wr), .BUFFER_WRITE(buf_wr), .BUFFER_WRITE_DATA(buf_data),
    .COMPANION_MATCH_IRQ(comp_irq), .CARRIER_OUT_PIN(pin), .TIMER_MATCH_IRQ(irq),
    .SYNCED_COMPANION_EVENT(sync_ev), .CARRIER_ENABLE_BUFFER(en_buf),
    .CARRIER_ENABLE_ACTIVE(en_act), .COUNT_VALUE(count));
  companion_counter_model companion_u (.clock(clock), .run_enable(comp_run),
    .match_irq(comp_irq));
  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask
  // Cycles up to the next match pulse; a lost pulse ends the run
  task automatic next_irq();
    gap = 0;
    do begin
      tick(1);
      gap++;
    end while (irq !== 1'b1 && gap < 600);
    if (gap >= 600) begin
      errors++;
      print_verdict();
    end
  endtask
  // Buffer write, then one companion match moves it to the active bit
  task automatic set_active(input logic v);
    int n;
    n = 0;
    buf_data = v;
    buf_wr = 1'b1;
    tick(1);
    buf_wr = 1'b0;
    comp_run = 1'b1;
    while (en_act !== v && n < 200) begin
      tick(1);
      n++;
    end
    // A transfer that never comes ends the run
    if (n >= 200) begin
      errors++;
      print_verdict();
    end
    check("synced event", {7'h00, sync_ev}, 8'h01);
    comp_run = 1'b0;
    check("buffer", {7'h00, en_buf}, {7'h00, v});
    check("active", {7'h00, en_act}, {7'h00, v});
  endtask
  // Stop, set mode and both widths, then run; high width rewritten each start
  task automatic start(input logic [7:0] n, input logic [7:0] m, input logic rmt,
      input logic pin_exp);
    run = 1'b0;
    tick(2);
    remote = rmt;
    low_w = n;
    high_w = m;
    high_wr = 1'b1;
    tick(1);
    high_wr = 1'b0;
    run = 1'b1;
    tick(1);
    check("pin at start", {7'h00, pin}, 8'h00);
    next_irq();
    check("pin first low match", {7'h00, pin}, {7'h00, pin_exp});
  endtask
  // Two full carrier periods: high M+1, low N+1
  task automatic t_carrier();
    set_active(1'b1);
    start(8'h02, 8'h01, 1'b1, 1'b1);
    repeat (2) begin
      next_irq();
      check("high width", 8'(gap), 8'h02);
      check("pin after high", {7'h00, pin}, 8'h00);
      next_irq();
      check("low width", 8'(gap), 8'h03);
    end
    $display("test carrier done");
  endtask
  // New high width waits for a match on the old one; a write too close to
  // that match waits one more high phase
  task automatic t_rewrite();
    next_irq();
    high_w = 8'h04;
    high_wr = 1'b1;
    tick(1);
    high_wr = 1'b0;
    next_irq();
    next_irq();
    check("old high width", 8'(gap), 8'h02);
    next_irq();
    next_irq();
    check("held high width", 8'(gap), 8'h02);
    next_irq();
    next_irq();
    check("new high width", 8'(gap), 8'h05);
    $display("test rewrite done");
  endtask
  // Gate off in mid-run, then the plain level mode
  task automatic t_gate();
    set_active(1'b0);
    tick(8);
    check("pin gated off", {7'h00, pin}, 8'h00);
    start(8'h01, 8'h01, 1'b0, 1'b0);
    set_active(1'b1);
    tick(2);
    check("pin level mode", {7'h00, pin}, 8'h01);
    run = 1'b0;
    tick(3);
    check("count stopped", count, 8'h00);
    check("irq stopped", {7'h00, irq}, 8'h00);
    $display("test gate done");
  endtask
  initial begin
    tick(2);
    reset = 1'b0;
    tick(1);
    check("count after reset", count, 8'h00);
    check("active after reset", {7'h00, en_act}, 8'h00);
    t_carrier();
    t_rewrite();
    t_gate();
    print_verdict();
  end
endmodule
